// file: rtl/dshf_consts.vh
// Purpose: Constants for the spread-spectrum header field block
// Assumes: Byte addresses on the control port, 8-bit registers
// Notes:   Codes reset to the usual header values
//
// Operation
// - SFD search time, eight bits, symbols
// - No SFD in time: back to acquisition
// - Two-bit selector picks transmitted code register
// - Upper six rate bits: plain storage
// - Service byte transmitted; keep it zero
// - Sixteen-bit transmit length from two bytes
// - Status top bits show detected rate
// - Bit five: carrier acquired, cleared unless enabled
// - Bit four: SFD found, cleared unless enabled
// - Bit three: signal field matched a code
// - Bit two: header CRC valid
// - Bit one: antenna at last good CRC
// - Status ignores writes, bit zero reads zero
// - Received service byte readable
// - Received length high byte readable
// - Received length low byte readable
`ifndef DSHF_CONSTS_VH
`define DSHF_CONSTS_VH

// Register byte addresses
`define DSHF_A_SFD_TMO   7'h3C
`define DSHF_A_CODE_1M   7'h40
`define DSHF_A_CODE_2M   7'h44
`define DSHF_A_CODE_5M5  7'h48
`define DSHF_A_CODE_11M  7'h4C
`define DSHF_A_TX_RATE   7'h50
`define DSHF_A_TX_SVC    7'h54
`define DSHF_A_TX_LEN_HI 7'h58
`define DSHF_A_TX_LEN_LO 7'h5C
`define DSHF_A_RX_FLAGS  7'h60
`define DSHF_A_RX_SVC    7'h64
`define DSHF_A_RX_LEN_HI 7'h68
`define DSHF_A_RX_LEN_LO 7'h6C

// Reset values
`define DSHF_R_SFD_TMO   8'h80
`define DSHF_R_CODE_1M   8'h0A
`define DSHF_R_CODE_2M   8'h14
`define DSHF_R_CODE_5M5  8'h37
`define DSHF_R_CODE_11M  8'h6E

// Rate field and status bit positions
`define DSHF_RATE_MSB    1
`define DSHF_F_RATE_MSB  7
`define DSHF_F_RATE_LSB  6
`define DSHF_F_ACQ       5
`define DSHF_F_SFD       4
`define DSHF_F_SIGOK     3
`define DSHF_F_CRCOK     2
`define DSHF_F_ANT_A     1

`endif

// file: rtl/dshf_sfd_search_timeout.v
// Purpose: SFD search timer counting symbol periods
// Assumes: One tick per symbol from the demodulator
// Notes:   A load of zero expires on the first tick
`timescale 1ns/10ps
`default_nettype none
module dshf_sfd_search_timeout #(
	parameter W = 8
) (
	input  wire         clk_i,    // Clock
	input  wire         rst_i,    // Sync reset
	input  wire         start_i,  // Load and run
	input  wire         stop_i,   // Halt count
	input  wire         tick_i,   // Symbol tick
	input  wire [W-1:0] limit_i,  // Search length
	output reg          expire_o  // Timeout pulse
);
	reg [W-1:0] cnt_q;
	reg         run_q;

	always @(posedge clk_i) begin
		expire_o <= 1'b0;
		// Start beats stop: the load arrives while still in search
		if (rst_i || (stop_i && !start_i)) begin
			run_q <= 1'b0;
			cnt_q <= {W{1'b0}};
		end else if (start_i) begin
			run_q <= 1'b1;
			cnt_q <= limit_i;
		end else if (run_q && tick_i) begin
			if (cnt_q == {W{1'b0}}) begin
				run_q    <= 1'b0;
				expire_o <= 1'b1;
			end else begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // dshf_sfd_search_timeout
`default_nettype wire

// file: rtl/dshf_sig_classify.v
// Purpose: Classify a received signal byte against four codes
// Assumes: Codes are distinct; lowest rate wins on a tie
// Notes:   Result registered one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module dshf_sig_classify (
	input  wire       clk_i,    // Clock
	input  wire       rst_i,    // Sync reset
	input  wire       stb_i,    // Signal byte valid
	input  wire [7:0] sig_i,    // Received byte
	input  wire [31:0] codes_i, // Codes, 1M in low byte
	output reg        done_o,   // Result pulse
	output reg        hit_o,    // Byte matched
	output reg  [1:0] rate_o    // Matched rate
);
	function [2:0] match;
		input [7:0]  s;
		input [31:0] c;
		integer      k;
		begin
			match = 3'h0;
			for (k = 3; k >= 0; k = k - 1)
				if (c[k*8 +: 8] == s)
					match = {1'b1, k[1:0]};
		end
	endfunction

	always @(posedge clk_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
			hit_o  <= 1'b0;
			rate_o <= 2'h0;
		end else begin
			done_o <= stb_i;
			if (stb_i)
				{hit_o, rate_o} <= match(sig_i, codes_i);
		end
	end
endmodule // dshf_sig_classify
`default_nettype wire

// file: rtl/dshf_top.v
// Purpose: Header field registers and receive header tracking
// Assumes: Parallel control port, header bytes from demodulator
// Notes:   Header bytes arrive signal, service, length lo, hi
`timescale 1ns/10ps
`default_nettype none
`include "dshf_consts.vh"
module dshf_top (
	input  wire       CLK_I,                  // 125 MHz clock
	input  wire       RST_I,                  // Sync reset, high
	// Control port
	input  wire [6:0] CTL_ADDR_I,             // Byte address
	input  wire       CTL_WR_I,               // Write strobe
	input  wire       CTL_RD_I,               // Read strobe
	input  wire [7:0] CTL_WDATA_I,            // Write data
	output reg  [7:0] CTL_RDATA_O,            // Read data
	output reg        CTL_RVALID_O,           // Read data valid
	// Receive side
	input  wire       RECEIVE_PATH_ENABLE_I,  // Receiver enabled
	input  wire       CARRIER_ACQ_I,          // Carrier acquired pulse
	input  wire       SYMBOL_TICK_I,          // Symbol period tick
	input  wire       SFD_FOUND_I,            // SFD detected pulse
	input  wire       HDR_BYTE_VLD_I,         // Header byte strobe
	input  wire [7:0] HDR_BYTE_I,             // Header byte
	input  wire       HDR_CRC_DONE_I,         // CRC checked pulse
	input  wire       HDR_CRC_OK_I,           // CRC result
	input  wire       ANTENNA_A_I,            // Antenna A in use
	input  wire       RX_END_I,               // Frame over pulse
	output reg        RX_ABORT_O,             // Back to acquisition
	output reg        RX_RATE_VLD_O,          // Payload rate known
	output reg  [1:0] RX_RATE_O,              // Payload rate
	// Transmit side
	input  wire       TX_HDR_START_I,         // Header start pulse
	output reg  [7:0] TX_SIGNAL_O,            // Signal field
	output reg  [7:0] TX_SERVICE_O,           // Service field
	output reg [15:0] TX_LENGTH_O             // Length in bits
);
	//----------------------------------------
	// Receive states
	//----------------------------------------
	localparam [1:0] ST_SEARCH = 2'h0;
	localparam [1:0] ST_SFD    = 2'h1;
	localparam [1:0] ST_HDR    = 2'h2;
	localparam [1:0] ST_DATA   = 2'h3;

	//----------------------------------------
	// Registers
	//----------------------------------------
	reg [7:0]  sfd_tmo_q;
	reg [31:0] codes_q;       // 1M, 2M, 5M5, 11M from low byte
	reg [7:0]  tx_rate_q;
	reg [7:0]  tx_svc_q;
	reg [7:0]  tx_len_hi_q;
	reg [7:0]  tx_len_lo_q;
	reg [1:0]  st_q;
	reg [1:0]  st_d;
	reg [1:0]  byte_ix_q;
	reg        hdr_full_q;    // Four header bytes taken
	reg [7:0]  sh_svc_q;      // Shadow fields during parse
	reg [7:0]  sh_len_lo_q;
	reg [7:0]  sh_len_hi_q;
	reg [7:0]  rx_svc_q;
	reg [7:0]  rx_len_lo_q;
	reg [7:0]  rx_len_hi_q;
	reg [1:0]  rx_rate_q;
	reg        f_sfd_q;
	reg        f_sig_q;
	reg        f_crc_q;
	reg        f_ant_q;
	reg [7:0]  rd_d;

	wire       tmo_expire;
	wire       cls_done;
	wire       cls_hit;
	wire [1:0] cls_rate;
	wire       en;
	wire       wr;
	wire       sig_stb;

	assign en      = RECEIVE_PATH_ENABLE_I;
	assign wr      = CTL_WR_I;
	assign sig_stb = (st_q == ST_HDR) && HDR_BYTE_VLD_I && (byte_ix_q == 2'h0);

	// Address match helper
	function sel;
		input [6:0] a;
		input [6:0] b;
		begin
			sel = (a == b);
		end
	endfunction

	//----------------------------------------
	// Helper blocks
	//----------------------------------------
	dshf_sfd_search_timeout #(
		.W(8)
	) u_tmr (
		.clk_i    (CLK_I),
		.rst_i    (RST_I),
		.start_i  (en && (st_q == ST_SEARCH) && CARRIER_ACQ_I),
		.stop_i   (!en || (st_q != ST_SFD) || SFD_FOUND_I),
		.tick_i   (SYMBOL_TICK_I),
		.limit_i  (sfd_tmo_q),
		.expire_o (tmo_expire)
	);

	dshf_sig_classify u_cls (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.stb_i   (sig_stb),
		.sig_i   (HDR_BYTE_I),
		.codes_i (codes_q),
		.done_o  (cls_done),
		.hit_o   (cls_hit),
		.rate_o  (cls_rate)
	);

	//----------------------------------------
	// Configuration writes
	//----------------------------------------
	// Status addresses are not decoded here, so writes there drop
	always @(posedge CLK_I) begin
		if (RST_I) begin
			sfd_tmo_q   <= `DSHF_R_SFD_TMO;
			codes_q     <= {`DSHF_R_CODE_11M, `DSHF_R_CODE_5M5,
			                `DSHF_R_CODE_2M, `DSHF_R_CODE_1M};
			tx_rate_q   <= 8'h00;
			tx_svc_q    <= 8'h00;
			tx_len_hi_q <= 8'h00;
			tx_len_lo_q <= 8'h00;
		end else if (wr) begin
			if (sel(CTL_ADDR_I, `DSHF_A_SFD_TMO))
				sfd_tmo_q <= CTL_WDATA_I;
			if (sel(CTL_ADDR_I, `DSHF_A_CODE_1M))
				codes_q[7:0] <= CTL_WDATA_I;
			if (sel(CTL_ADDR_I, `DSHF_A_CODE_2M))
				codes_q[15:8] <= CTL_WDATA_I;
			if (sel(CTL_ADDR_I, `DSHF_A_CODE_5M5))
				codes_q[23:16] <= CTL_WDATA_I;
			if (sel(CTL_ADDR_I, `DSHF_A_CODE_11M))
				codes_q[31:24] <= CTL_WDATA_I;
			if (sel(CTL_ADDR_I, `DSHF_A_TX_RATE))
				tx_rate_q <= CTL_WDATA_I;
			if (sel(CTL_ADDR_I, `DSHF_A_TX_SVC))
				tx_svc_q <= CTL_WDATA_I;
			if (sel(CTL_ADDR_I, `DSHF_A_TX_LEN_HI))
				tx_len_hi_q <= CTL_WDATA_I;
			if (sel(CTL_ADDR_I, `DSHF_A_TX_LEN_LO))
				tx_len_lo_q <= CTL_WDATA_I;
		end
	end

	//----------------------------------------
	// Transmit header fields
	//----------------------------------------
	// Sampled once per frame so mid-frame writes cannot tear it
	always @(posedge CLK_I) begin
		if (RST_I) begin
			TX_SIGNAL_O  <= 8'h00;
			TX_SERVICE_O <= 8'h00;
			TX_LENGTH_O  <= 16'h0000;
		end else if (TX_HDR_START_I) begin
			TX_SIGNAL_O  <= codes_q[tx_rate_q[`DSHF_RATE_MSB:0]*8 +: 8];
			TX_SERVICE_O <= tx_svc_q;
			TX_LENGTH_O  <= {tx_len_hi_q, tx_len_lo_q};
		end
	end

	//----------------------------------------
	// Receive header state machine
	//----------------------------------------
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_SEARCH: begin
				if (CARRIER_ACQ_I)
					st_d = ST_SFD;
			end
			ST_SFD: begin
				if (tmo_expire)
					st_d = ST_SEARCH;
				else if (SFD_FOUND_I)
					st_d = ST_HDR;
			end
			ST_HDR: begin
				if (HDR_CRC_DONE_I)
					st_d = HDR_CRC_OK_I ? ST_DATA : ST_SEARCH;
			end
			ST_DATA: begin
				if (RX_END_I)
					st_d = ST_SEARCH;
			end
			default: st_d = ST_SEARCH;
		endcase
		if (!en)
			st_d = ST_SEARCH;
	end

	always @(posedge CLK_I) begin
		if (RST_I)
			st_q <= ST_SEARCH;
		else
			st_q <= st_d;
	end

	//----------------------------------------
	// Header byte capture
	//----------------------------------------
	// Fields land in shadows; bytes past the fourth are ignored
	always @(posedge CLK_I) begin
		if (RST_I) begin
			byte_ix_q   <= 2'h0;
			hdr_full_q  <= 1'b0;
			sh_svc_q    <= 8'h00;
			sh_len_lo_q <= 8'h00;
			sh_len_hi_q <= 8'h00;
		end else if (st_q != ST_HDR) begin
			byte_ix_q  <= 2'h0;
			hdr_full_q <= 1'b0;
		end else if (HDR_BYTE_VLD_I && !hdr_full_q) begin
			case (byte_ix_q)
				2'h1: sh_svc_q    <= HDR_BYTE_I;
				2'h2: sh_len_lo_q <= HDR_BYTE_I;
				2'h3: sh_len_hi_q <= HDR_BYTE_I;
				default: ;
			endcase
			if (byte_ix_q == 2'h3)
				hdr_full_q <= 1'b1;
			else
				byte_ix_q <= byte_ix_q + 2'h1;
		end
	end

	//----------------------------------------
	// Received field status
	//----------------------------------------
	// Commit on a good CRC only, so status shows whole headers
	always @(posedge CLK_I) begin
		if (RST_I) begin
			rx_svc_q    <= 8'h00;
			rx_len_lo_q <= 8'h00;
			rx_len_hi_q <= 8'h00;
			f_ant_q     <= 1'b0;
		end else if (en && st_q == ST_HDR && HDR_CRC_DONE_I && HDR_CRC_OK_I) begin
			rx_svc_q    <= sh_svc_q;
			rx_len_lo_q <= sh_len_lo_q;
			rx_len_hi_q <= sh_len_hi_q;
			f_ant_q     <= ANTENNA_A_I;
		end
	end

	//----------------------------------------
	// Receive flags
	//----------------------------------------
	// Hardware-set flags: a new SFD clears the previous header's
	always @(posedge CLK_I) begin
		if (RST_I) begin
			f_sfd_q   <= 1'b0;
			f_sig_q   <= 1'b0;
			f_crc_q   <= 1'b0;
			rx_rate_q <= 2'h0;
		end else if (!en) begin
			f_sfd_q <= 1'b0;
			f_sig_q <= 1'b0;
			f_crc_q <= 1'b0;
		end else begin
			if (st_q == ST_SFD && SFD_FOUND_I && !tmo_expire) begin
				f_sfd_q <= 1'b1;
				f_sig_q <= 1'b0;
				f_crc_q <= 1'b0;
			end else if (st_d == ST_SEARCH) begin
				f_sfd_q <= 1'b0;
			end
			if (cls_done && cls_hit) begin
				f_sig_q   <= 1'b1;
				rx_rate_q <= cls_rate;
			end
			if (st_q == ST_HDR && HDR_CRC_DONE_I && HDR_CRC_OK_I)
				f_crc_q <= 1'b1;
		end
	end

	//----------------------------------------
	// Rate and abort outputs
	//----------------------------------------
	// Rate is announced only for a header that passed CRC
	always @(posedge CLK_I) begin
		if (RST_I) begin
			RX_ABORT_O    <= 1'b0;
			RX_RATE_VLD_O <= 1'b0;
			RX_RATE_O     <= 2'h0;
		end else begin
			RX_ABORT_O    <= en && (st_q == ST_SFD) && tmo_expire;
			RX_RATE_VLD_O <= en && (st_d == ST_DATA) && f_sig_q;
			RX_RATE_O     <= rx_rate_q;
		end
	end

	//----------------------------------------
	// Read path
	//----------------------------------------
	always @* begin
		rd_d = 8'h00;
		case (CTL_ADDR_I)
			`DSHF_A_SFD_TMO:   rd_d = sfd_tmo_q;
			`DSHF_A_CODE_1M:   rd_d = codes_q[7:0];
			`DSHF_A_CODE_2M:   rd_d = codes_q[15:8];
			`DSHF_A_CODE_5M5:  rd_d = codes_q[23:16];
			`DSHF_A_CODE_11M:  rd_d = codes_q[31:24];
			`DSHF_A_TX_RATE:   rd_d = tx_rate_q;
			`DSHF_A_TX_SVC:    rd_d = tx_svc_q;
			`DSHF_A_TX_LEN_HI: rd_d = tx_len_hi_q;
			`DSHF_A_TX_LEN_LO: rd_d = tx_len_lo_q;
			`DSHF_A_RX_FLAGS: begin
				rd_d[`DSHF_F_RATE_MSB:`DSHF_F_RATE_LSB] = rx_rate_q;
				rd_d[`DSHF_F_ACQ]   = en && (st_q != ST_SEARCH);
				rd_d[`DSHF_F_SFD]   = f_sfd_q;
				rd_d[`DSHF_F_SIGOK] = f_sig_q;
				rd_d[`DSHF_F_CRCOK] = f_crc_q;
				rd_d[`DSHF_F_ANT_A] = f_ant_q;
				rd_d[0]             = 1'b0;
			end
			`DSHF_A_RX_SVC:    rd_d = rx_svc_q;
			`DSHF_A_RX_LEN_HI: rd_d = rx_len_hi_q;
			`DSHF_A_RX_LEN_LO: rd_d = rx_len_lo_q;
			default:           rd_d = 8'h00;
		endcase
	end

	// Read data registered; unmapped addresses answer zero
	always @(posedge CLK_I) begin
		if (RST_I) begin
			CTL_RDATA_O  <= 8'h00;
			CTL_RVALID_O <= 1'b0;
		end else begin
			CTL_RVALID_O <= CTL_RD_I;
			if (CTL_RD_I)
				CTL_RDATA_O <= rd_d;
		end
	end
endmodule // dshf_top
`default_nettype wire

// file: tb/dshf_mac_model.sv
// Purpose: Controller model driving the parallel control port
// Assumes: Strobes are sampled on the rising clock edge
// Notes:   Write data is inverted once a write is released
`timescale 1ns/10ps
`default_nettype none
module dshf_mac_model (
	input  wire logic       clk_i,   // Clock
	input  wire logic [7:0] rdata_i, // Read data
	output var  logic [6:0] addr_o,  // Address
	output var  logic       wr_o,    // Write strobe
	output var  logic       rd_o,    // Read strobe
	output var  logic [7:0] wdata_o  // Write data
);
	// Idle bus from time zero
	initial begin
		{addr_o, wr_o, rd_o, wdata_o} = '0;
	end

	// One write, strobe held for a single edge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_i) begin
			addr_o <= a;
			wdata_o <= d;
			wr_o <= 1'b1;
		end
		@(posedge clk_i) begin
			wr_o <= 1'b0;
			wdata_o <= ~d;
		end
	endtask

	// One read, data taken at the edge where valid is seen
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_i) begin
			addr_o <= a;
			rd_o <= 1'b1;
		end
		@(posedge clk_i) rd_o <= 1'b0;
		@(posedge clk_i) d = rdata_i;
	endtask

	task automatic init;
		wr(7'h40, 8'h0A);
		wr(7'h44, 8'h14);
		wr(7'h48, 8'h37);
		wr(7'h4C, 8'h6E);
		wr(7'h54, 8'h00);
	endtask

	task automatic settle;
		repeat (250) @(posedge clk_i);
	endtask
endmodule // dshf_mac_model
`default_nettype wire

// file: tb/dshf_top_sva.sv
// Purpose: Port checks for the header field block
// Assumes: Write mirror tracks codes, rate, service, length
// Notes:   Mirror resets to the same values as the block
`timescale 1ns/10ps
`default_nettype none
module dshf_top_sva (
	input wire logic        CLK_I,                 // Clock
	input wire logic        RST_I,                 // Reset
	input wire logic [6:0]  CTL_ADDR_I,            // Address
	input wire logic        CTL_WR_I,              // Write
	input wire logic        CTL_RD_I,              // Read
	input wire logic [7:0]  CTL_WDATA_I,           // Write data
	input wire logic [7:0]  CTL_RDATA_O,           // Read data
	input wire logic        CTL_RVALID_O,          // Read valid
	input wire logic        RECEIVE_PATH_ENABLE_I, // Rx enable
	input wire logic        HDR_CRC_DONE_I,        // CRC done
	input wire logic        HDR_CRC_OK_I,          // CRC good
	input wire logic        RX_END_I,              // Frame end
	input wire logic        RX_RATE_VLD_O,         // Rate valid
	input wire logic        TX_HDR_START_I,        // Tx start
	input wire logic [7:0]  TX_SIGNAL_O,           // Tx signal
	input wire logic [7:0]  TX_SERVICE_O,          // Tx service
	input wire logic [15:0] TX_LENGTH_O            // Tx length
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	logic [7:0] m [0:7];
	logic [7:0] sel;
	assign sel = m[m[4][1:0]];
	// Mirror of 40h..5Ch, so transmit outputs can be predicted
	always @(posedge CLK_I) begin
		if (RST_I) begin
			m <= '{8'h0A, 8'h14, 8'h37, 8'h6E, 8'h00, 8'h00, 8'h00, 8'h00};
		end else if (CTL_WR_I && CTL_ADDR_I[6:5] == 2'b10) begin
			m[CTL_ADDR_I[4:2]] <= CTL_WDATA_I;
		end
	end
	sequence s_off_rd;
		!RECEIVE_PATH_ENABLE_I ##1 (!RECEIVE_PATH_ENABLE_I && CTL_RD_I && CTL_ADDR_I == 7'h60);
	endsequence
	property p_rd_vld; CTL_RVALID_O == $past(CTL_RD_I); endproperty
	property p_bit0; CTL_RD_I && CTL_ADDR_I == 7'h60 |=> !CTL_RDATA_O[0]; endproperty
	property p_dis; s_off_rd |=> CTL_RDATA_O[5:2] == 4'h0; endproperty
	property p_rate_rd; CTL_RD_I && CTL_ADDR_I == 7'h50 |=> CTL_RDATA_O == $past(m[4]); endproperty
	property p_tx_sig; TX_HDR_START_I |=> TX_SIGNAL_O == $past(sel); endproperty
	property p_tx_len; TX_HDR_START_I |=> TX_LENGTH_O == $past({m[6], m[7]}) && TX_SERVICE_O == $past(m[5]); endproperty
	property p_tx_hold; !TX_HDR_START_I |=> $stable({TX_SIGNAL_O, TX_SERVICE_O, TX_LENGTH_O}); endproperty
	property p_vld_rise; $rose(RX_RATE_VLD_O) |-> $past(HDR_CRC_DONE_I && HDR_CRC_OK_I); endproperty
	property p_vld_off; !RECEIVE_PATH_ENABLE_I |=> !RX_RATE_VLD_O; endproperty
	property p_end; RX_END_I |=> !RX_RATE_VLD_O; endproperty
	a_rd_vld: assert property (p_rd_vld) else $error("read valid not one cycle after read");
	a_bit0: assert property (p_bit0) else $error("status bit 0 not zero");
	a_dis: assert property (p_dis) else $error("status flags set while disabled");
	a_rate_rd: assert property (p_rate_rd) else $error("rate register readback wrong");
	a_tx_sig: assert property (p_tx_sig) else $error("tx signal code wrong");
	a_tx_len: assert property (p_tx_len) else $error("tx length or service wrong");
	a_tx_hold: assert property (p_tx_hold) else $error("tx fields changed without start");
	a_vld_rise: assert property (p_vld_rise) else $error("rate valid without good CRC");
	a_vld_off: assert property (p_vld_off) else $error("rate valid while disabled");
	a_end: assert property (p_end) else $error("rate valid after frame end");
endmodule // dshf_top_sva
`default_nettype wire

// file: tb/dshf_top_tb.sv
// Purpose: Self-checking bench for the header field block
// Assumes: Receive events driven here, control port by the model
// Notes:   Header bytes sent signal, service, length lo, hi
`timescale 1ns/10ps
`default_nettype none
module dshf_top_tb;
	logic              CLK_I = 0, RST_I = 1, RECEIVE_PATH_ENABLE_I = 0, CARRIER_ACQ_I = 0;
	logic              SYMBOL_TICK_I = 0, SFD_FOUND_I = 0, HDR_BYTE_VLD_I = 0, HDR_CRC_DONE_I = 0;
	logic              HDR_CRC_OK_I = 0, ANTENNA_A_I = 0, RX_END_I = 0, TX_HDR_START_I = 0;
	logic [7:0]        HDR_BYTE_I = 8'h00, v;
	wire logic [6:0]   CTL_ADDR_I;
	wire logic         CTL_WR_I, CTL_RD_I, CTL_RVALID_O, RX_ABORT_O, RX_RATE_VLD_O;
	wire logic [7:0]   CTL_WDATA_I, CTL_RDATA_O, TX_SIGNAL_O, TX_SERVICE_O;
	wire logic [1:0]   RX_RATE_O;
	wire logic [15:0]  TX_LENGTH_O;
	int                n_errors = 0, n_tests = 0, n_abort = 0;
	localparam logic [31:0]  CODES = 32'h6E37140A;
	localparam logic [111:0] RVAL = {72'h0, 40'h6E37140A80};
	dshf_top u_dut (.CLK_I, .RST_I, .CTL_ADDR_I, .CTL_WR_I, .CTL_RD_I, .CTL_WDATA_I, .CTL_RDATA_O,
		.CTL_RVALID_O, .RECEIVE_PATH_ENABLE_I, .CARRIER_ACQ_I, .SYMBOL_TICK_I, .SFD_FOUND_I,
		.HDR_BYTE_VLD_I, .HDR_BYTE_I, .HDR_CRC_DONE_I, .HDR_CRC_OK_I, .ANTENNA_A_I, .RX_END_I,
		.RX_ABORT_O, .RX_RATE_VLD_O, .RX_RATE_O, .TX_HDR_START_I, .TX_SIGNAL_O, .TX_SERVICE_O, .TX_LENGTH_O);
	dshf_mac_model u_mac (.clk_i(CLK_I), .rdata_i(CTL_RDATA_O), .addr_o(CTL_ADDR_I), .wr_o(CTL_WR_I),
		.rd_o(CTL_RD_I), .wdata_o(CTL_WDATA_I));
	always #4 CLK_I = ~CLK_I;
	// Abort pulses counted so the timeout boundary can be judged
	always @(posedge CLK_I) if (RX_ABORT_O === 1'b1) n_abort++;

	task automatic chk(input logic [15:0] e, g, input string n);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		u_mac.rd(a, v);
		chk(16'(e), 16'(v), $sformatf("reg %h", a));
	endtask
	task automatic tick;
		@(posedge CLK_I) SYMBOL_TICK_I <= 1;
		@(posedge CLK_I) SYMBOL_TICK_I <= 0;
	endtask
	task automatic start;
		@(posedge CLK_I) TX_HDR_START_I <= 1;
		@(posedge CLK_I) TX_HDR_START_I <= 0;
		#1;
	endtask
	// Whole header: acquire, SFD, four bytes, CRC verdict
	task automatic frame(input logic [31:0] b, input logic ok, ant);
		@(posedge CLK_I) CARRIER_ACQ_I <= 1;
		@(posedge CLK_I) begin
			CARRIER_ACQ_I <= 0;
			SFD_FOUND_I <= 1;
		end
		for (int i = 0; i < 4; i++) @(posedge CLK_I) begin
			SFD_FOUND_I <= 0;
			HDR_BYTE_VLD_I <= 1;
			HDR_BYTE_I <= b[8*i+:8];
		end
		@(posedge CLK_I) begin
			HDR_BYTE_VLD_I <= 0;
			HDR_BYTE_I <= ~HDR_BYTE_I;
			HDR_CRC_DONE_I <= 1;
			HDR_CRC_OK_I <= ok;
			ANTENNA_A_I <= ant;
		end
		@(posedge CLK_I) HDR_CRC_DONE_I <= 0;
		@(posedge CLK_I);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge CLK_I);
		RST_I <= 0;
		for (int i = 0; i < 14; i++) rdc(7'(8'h3C + 4 * i), RVAL[8*i+:8]);
		u_mac.wr(7'h60, 8'hFF);
		rdc(7'h60, 8'h00);
		u_mac.init();
		u_mac.wr(7'h3C, 8'h02);
		rdc(7'h3C, 8'h02);
		$display("test registers done");
		u_mac.wr(7'h58, 8'h12);
		u_mac.wr(7'h5C, 8'h34);
		for (int r = 0; r < 4; r++) begin
			u_mac.wr(7'h50, 8'hA8 | 8'(r));
			u_mac.settle();
			rdc(7'h50, 8'hA8 | 8'(r));
			start();
			chk(16'(CODES[8*r+:8]), 16'(TX_SIGNAL_O), "tx signal");
			chk(16'h1234, TX_LENGTH_O, "tx length");
		end
		u_mac.wr(7'h5C, 8'h99);
		#1 chk(16'h1234, TX_LENGTH_O, "tx length held");
		chk(16'h0000, 16'(TX_SERVICE_O), "tx service");
		start();
		chk(16'h1299, TX_LENGTH_O, "tx length next");
		$display("test transmit done");
		@(posedge CLK_I) RECEIVE_PATH_ENABLE_I <= 1;
		frame(32'h5634A56E, 1'b1, 1'b1);
		rdc(7'h60, 8'hFE);
		chk(16'h0001, 16'(RX_RATE_VLD_O), "rate valid");
		chk(16'h0003, 16'(RX_RATE_O), "rate");
		rdc(7'h64, 8'hA5);
		rdc(7'h68, 8'h56);
		rdc(7'h6C, 8'h34);
		@(posedge CLK_I) RX_END_I <= 1;
		@(posedge CLK_I) RX_END_I <= 0;
		frame(32'h1111110A, 1'b0, 1'b0);
		rdc(7'h64, 8'hA5);
		rdc(7'h68, 8'h56);
		frame(32'h00000055, 1'b1, 1'b0);
		u_mac.rd(7'h60, v);
		chk(16'h0000, 16'(v & 8'h0B), "flags unmatched");
		@(posedge CLK_I) RECEIVE_PATH_ENABLE_I <= 0;
		repeat (2) @(posedge CLK_I);
		u_mac.rd(7'h60, v);
		chk(16'h0000, 16'(v & 8'h3D), "flags disabled");
		$display("test receive done");
		@(posedge CLK_I) RECEIVE_PATH_ENABLE_I <= 1;
		@(posedge CLK_I) CARRIER_ACQ_I <= 1;
		@(posedge CLK_I) CARRIER_ACQ_I <= 0;
		tick();
		tick();
		repeat (4) @(posedge CLK_I);
		chk(16'h0000, 16'(n_abort), "early abort");
		tick();
		repeat (5) @(posedge CLK_I);
		chk(16'h0001, 16'(n_abort), "abort");
		u_mac.rd(7'h60, v);
		chk(16'h0000, 16'(v[4]), "sfd flag");
		$display("test timeout done");
		results();
	end
	// Cut a hang short
	initial begin
		#400000;
		n_errors++;
		results();
	end
endmodule // dshf_top_tb
bind dshf_top dshf_top_sva u_sva (.CLK_I, .RST_I, .CTL_ADDR_I, .CTL_WR_I, .CTL_RD_I, .CTL_WDATA_I,
	.CTL_RDATA_O, .CTL_RVALID_O, .RECEIVE_PATH_ENABLE_I, .HDR_CRC_DONE_I, .HDR_CRC_OK_I, .RX_END_I,
	.RX_RATE_VLD_O, .TX_HDR_START_I, .TX_SIGNAL_O, .TX_SERVICE_O, .TX_LENGTH_O);
`default_nettype wire
